// ---- rtl/mbh_handler.sv ----
// Operation
// [RL1] Write quantity outside 1..16 gives exception 3
// [RL2] Byte count not twice quantity: exception 3
// [RL3] Bad start or range gives exception 2
// [RL4] Limit breach or protected gives exception 4
// [RL5] Writing read-only register gives exception 4
// [RL6] Start not item start gives exception 2
// [RL7] Writes into map gaps silently dropped
// [RL8] Partial last item write gives exception 4
// [RL9] Master sends fixed write query byte order
// [RL10] Write reply echoes address, function, start, quantity
// [RL11] Read reply: byte count, values high first
// [RL12] Sub-function 0 loops request data back
// [RL13] Sub-function 10, reset, restart clear counters
// [RL14] Sub-function 11 returns bus message count
// [RL15] Sub-function 12 returns CRC error count
// [RL16] Sub-function 13 returns exception count
// [RL17] Sub-function 14 returns processed message count
// [RL18] Sub-function 15 returns no-response count
// [RL19] Sub-function 16 returns NAK count
// [RL20] Sub-function 17 returns busy count
// [RL21] Sub-function 18 returns overrun count
// [RL22] Sub-function 20 clears overrun counter, flag
// [RL23] Only functions 3, 8, 16 accepted
// [RL24] Read gaps return zero bytes
// [RL25] Unsupported code gives exception 1, counted
// [RL26] Counters 16 bits, wrap, high first
`timescale 1ns/1ps
`include "mbh_consts.svh"
module mbh_handler (
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	input  wire logic [7:0]  own_address,
	input  wire logic        comm_restart,
	input  wire logic        rx_valid,
	input  wire logic [7:0]  rx_byte,
	input  wire logic        rx_last,
	input  wire logic        rx_overrun,
	input  wire logic        tx_ready,
	input  wire logic        map_addr_ok,
	input  wire logic        map_mapped,
	input  wire logic        map_item_first,
	input  wire logic        map_item_end,
	input  wire logic        map_writable,
	input  wire logic        map_value_ok,
	input  wire logic [15:0] map_rd_data,
	output logic             tx_valid,
	output logic      [7:0]  tx_byte,
	output logic             tx_last,
	output logic      [15:0] map_addr,
	output logic      [15:0] map_wr_data,
	output logic             map_wr_en,
	output logic             overrun_flag
);
	mbh_pkg::mbh_state_type_reg_type s_reg;
	mbh_pkg::mbh_state_type_reg_type s_next;
	logic [15:0]             start;
	logic [15:0]             qty;
	logic [7:0]              fc;
	logic [7:0]              bc;
	logic [15:0]             value_nxt;
	logic [15:0]             rx_crc_next;
	logic [15:0]             tx_crc_next;
	logic [7:0]              tx_src;
	logic [15:0]             cnt_val;
	logic [`MBH_LEN_W-1:0]   tidx_inc;
	logic                    broadcast;
	logic                    can_load;
	logic                    last_reg;

	// ==========================================
	// Request field views
	assign start     = {s_reg.rx_buf[`MBH_POS_HI], s_reg.rx_buf[`MBH_POS_LO]};
	assign qty       = {s_reg.rx_buf[`MBH_POS_QTY_HI], s_reg.rx_buf[`MBH_POS_QTY_LO]};
	assign fc        = s_reg.rx_buf[`MBH_POS_FC];
	assign bc        = s_reg.rx_buf[`MBH_POS_BC];
	assign broadcast = s_reg.rx_buf[`MBH_POS_ADDR] == `MBH_BROADCAST;
	assign value_nxt = {s_reg.rx_buf[`MBH_POS_DATA + 2 + 2 * s_reg.idx],
		s_reg.rx_buf[`MBH_POS_DATA + 3 + 2 * s_reg.idx]};
	assign cnt_val   = s_reg.cnt[3'(start - `MBH_SUB_CNT_FIRST)]; // RL26
	assign tidx_inc  = s_reg.tidx + 7'h01;
	assign can_load  = !s_reg.tx_valid || tx_ready;
	assign last_reg  = {11'h000, s_reg.idx} == qty - 16'h0001;

	// ==========================================
	// CRC steps: one on the receive stream, one on the reply
	mbh_crc16 u_rx_crc (
		.crc_in  (s_reg.crc),
		.data    (rx_byte),
		.crc_out (rx_crc_next)
	);
	mbh_crc16 u_tx_crc (
		.crc_in  (s_reg.crc),
		.data    (tx_src),
		.crc_out (tx_crc_next)
	);

	// Reply byte at the current index, chosen by reply kind
	always_comb begin
		logic [`MBH_LEN_W-1:0] rd_off;
		rd_off = s_reg.tidx - `MBH_LEN_READ_HDR;
		tx_src = s_reg.rx_buf[s_reg.tidx[5:0]];
		unique case (s_reg.kind)
			mbh_pkg::MBH_RSP_EXC: begin
				if (s_reg.tidx == 7'h01)
					tx_src = fc | `MBH_EXC_FLAG; // RL25
				else if (s_reg.tidx == 7'h02)
					tx_src = s_reg.exc_code;
			end
			mbh_pkg::MBH_RSP_ECHO: tx_src = s_reg.rx_buf[s_reg.tidx[5:0]]; // RL10 RL12
			mbh_pkg::MBH_RSP_COUNTER: begin
				if (s_reg.tidx == 7'h04)
					tx_src = cnt_val[15:8]; // RL26
				else if (s_reg.tidx == 7'h05)
					tx_src = cnt_val[7:0];
			end
			mbh_pkg::MBH_RSP_READ: begin
				if (s_reg.tidx == 7'h02)
					tx_src = {qty[6:0], 1'b0}; // RL11
				else if (s_reg.tidx >= `MBH_LEN_READ_HDR)
					tx_src = !map_mapped ? 8'h00 : (rd_off[0] ? map_rd_data[7:0] : map_rd_data[15:8]); // RL24
			end
		endcase
	end

	// ==========================================
	// Next-state logic for the whole handler
	always_comb begin
		logic ovr_event;
		ovr_event = 1'b0;
		s_next = s_reg;
		s_next.map_wr_en = 1'b0;
		unique case (s_reg.st)
			mbh_pkg::MBH_ST_IDLE: begin
				if (rx_overrun)
					s_next.ovr_seen = 1'b1;
				if (rx_valid) begin
					// Oversized frames keep their head; the tail is only checked by CRC
					if (s_reg.len < 7'(`MBH_BUF_DEPTH)) begin
						s_next.rx_buf[s_reg.len[5:0]] = rx_byte;
						s_next.len = s_reg.len + 7'h01;
					end
					s_next.crc = rx_crc_next;
				end
				if (rx_valid && rx_last) begin
					s_next.len = s_reg.len + 7'h01;
					s_next.ovr_seen = 1'b0;
					s_next.crc = `MBH_CRC_INIT;
					s_next.cnt[`MBH_CNT_BUS] = s_reg.cnt[`MBH_CNT_BUS] + 16'h0001; // RL14
					if (rx_crc_next != 16'h0000 || s_reg.len + 7'h01 < `MBH_MIN_FRAME) begin
						s_next.cnt[`MBH_CNT_CRC] = s_reg.cnt[`MBH_CNT_CRC] + 16'h0001; // RL15
						s_next.len = '0;
					end else if (s_reg.rx_buf[`MBH_POS_ADDR] != own_address && !broadcast) begin
						s_next.len = '0;
					end else begin
						s_next.cnt[`MBH_CNT_SLAVE] = s_reg.cnt[`MBH_CNT_SLAVE] + 16'h0001; // RL17
						if (s_reg.ovr_seen || rx_overrun) begin
							// Overrun frames are dropped without a reply
							s_next.cnt[`MBH_CNT_OVR] = s_reg.cnt[`MBH_CNT_OVR] + 16'h0001; // RL21
							s_next.cnt[`MBH_CNT_NORESP] = s_reg.cnt[`MBH_CNT_NORESP] + 16'h0001; // RL18
							s_next.ovr_flag = 1'b1;
							ovr_event = 1'b1;
							s_next.diag[0] = 1'b1;
							s_next.len = '0;
						end else
							s_next.st = mbh_pkg::MBH_ST_DECODE;
					end
				end
			end
			mbh_pkg::MBH_ST_DECODE: begin
				s_next.st = mbh_pkg::MBH_ST_REPLY;
				s_next.kind = mbh_pkg::MBH_RSP_EXC;
				s_next.exc_code = `MBH_EXC_FUNC; // RL23 RL25
				s_next.rsp_len = `MBH_LEN_EXC;
				if (fc == `MBH_FC_READ || fc == `MBH_FC_WRITE) begin
					if (qty == 16'h0000 || qty > `MBH_MAX_QTY)
						s_next.exc_code = `MBH_EXC_VALUE; // RL1
					else if (fc == `MBH_FC_WRITE && (bc != {qty[6:0], 1'b0} ||
						s_reg.len != `MBH_WR_OVERHEAD + 7'(bc)))
						s_next.exc_code = `MBH_EXC_VALUE; // RL2
					else if ({1'b0, start} + {1'b0, qty} > `MBH_ADDR_SPACE)
						s_next.exc_code = `MBH_EXC_ADDR; // RL3
					else begin
						s_next.st = mbh_pkg::MBH_ST_CHECK;
						s_next.exc_code = `MBH_EXC_NONE;
						s_next.idx = '0;
						s_next.map_addr = start;
						s_next.map_wr_data = {s_reg.rx_buf[`MBH_POS_DATA], s_reg.rx_buf[`MBH_POS_DATA + 1]};
					end
				end else if (fc == `MBH_FC_DIAG) begin
					s_next.kind = mbh_pkg::MBH_RSP_ECHO;
					s_next.rsp_len = s_reg.len - `MBH_LEN_CRC; // RL12
					if (start == `MBH_SUB_CLEAR) begin
						s_next.cnt = '0; // RL13
						s_next.diag = '0;
						s_next.ovr_flag = 1'b0;
					end else if (start == `MBH_SUB_CLR_OVR) begin
						s_next.cnt[`MBH_CNT_OVR] = '0; // RL22
						s_next.ovr_flag = 1'b0;
						s_next.diag[0] = 1'b0;
					end else if (start >= `MBH_SUB_CNT_FIRST && start <= `MBH_SUB_CNT_LAST) begin
						s_next.kind = mbh_pkg::MBH_RSP_COUNTER; // RL14 RL16 RL18 RL19 RL20 RL21
						s_next.rsp_len = `MBH_LEN_ECHO_HDR;
					end else if (start != `MBH_SUB_ECHO) begin
						s_next.kind = mbh_pkg::MBH_RSP_EXC;
						s_next.rsp_len = `MBH_LEN_EXC; // RL25
					end
				end
			end
			mbh_pkg::MBH_ST_CHECK: begin
				// Address faults end the scan at once; device faults wait in case one follows
				if (!map_addr_ok || (fc == `MBH_FC_WRITE && s_reg.idx == 5'h00 && !(map_mapped && map_item_first))) begin
					s_next.exc_code = `MBH_EXC_ADDR; // RL3 RL6
					s_next.kind = mbh_pkg::MBH_RSP_EXC;
					s_next.rsp_len = `MBH_LEN_EXC;
					s_next.st = mbh_pkg::MBH_ST_REPLY;
				end else begin
					if (fc == `MBH_FC_WRITE && map_mapped && (!map_writable || !map_value_ok))
						s_next.exc_code = `MBH_EXC_DEVICE; // RL4 RL5
					if (fc == `MBH_FC_WRITE && map_mapped && last_reg && !map_item_end)
						s_next.exc_code = `MBH_EXC_DEVICE; // RL8
					if (!last_reg) begin
						s_next.idx = s_reg.idx + 5'h01;
						s_next.map_addr = s_reg.map_addr + 16'h0001;
						s_next.map_wr_data = value_nxt;
					end else if (s_next.exc_code != `MBH_EXC_NONE) begin
						s_next.kind = mbh_pkg::MBH_RSP_EXC;
						s_next.rsp_len = `MBH_LEN_EXC;
						s_next.st = mbh_pkg::MBH_ST_REPLY;
					end else if (fc == `MBH_FC_WRITE) begin
						s_next.st = mbh_pkg::MBH_ST_WRITE;
						s_next.idx = '0;
						s_next.phase = 1'b0;
						s_next.map_addr = start;
						s_next.map_wr_data = {s_reg.rx_buf[`MBH_POS_DATA], s_reg.rx_buf[`MBH_POS_DATA + 1]};
					end else begin
						s_next.kind = mbh_pkg::MBH_RSP_READ;
						s_next.rsp_len = `MBH_LEN_READ_HDR + 7'({qty[5:0], 1'b0}); // RL11
						s_next.map_addr = start;
						s_next.st = mbh_pkg::MBH_ST_REPLY;
					end
				end
			end
			mbh_pkg::MBH_ST_WRITE: begin
				// Two cycles a register: strobe, then step the address
				if (!s_reg.phase) begin
					s_next.map_wr_en = map_mapped; // RL7
					s_next.phase = 1'b1;
				end else if (last_reg) begin
					s_next.kind = mbh_pkg::MBH_RSP_ECHO;
					s_next.rsp_len = `MBH_LEN_ECHO_HDR; // RL10
					s_next.st = mbh_pkg::MBH_ST_REPLY;
				end else begin
					s_next.phase = 1'b0;
					s_next.idx = s_reg.idx + 5'h01;
					s_next.map_addr = s_reg.map_addr + 16'h0001;
					s_next.map_wr_data = value_nxt;
				end
			end
			mbh_pkg::MBH_ST_REPLY: begin
				s_next.crc = `MBH_CRC_INIT;
				s_next.tidx = '0;
				if (broadcast) begin
					s_next.cnt[`MBH_CNT_NORESP] = s_reg.cnt[`MBH_CNT_NORESP] + 16'h0001; // RL18
					s_next.len = '0;
					s_next.st = mbh_pkg::MBH_ST_IDLE;
				end else begin
					if (s_reg.kind == mbh_pkg::MBH_RSP_EXC)
						s_next.cnt[`MBH_CNT_EXC] = s_reg.cnt[`MBH_CNT_EXC] + 16'h0001; // RL16 RL25
					s_next.st = mbh_pkg::MBH_ST_SEND;
				end
			end
			mbh_pkg::MBH_ST_SEND: begin
				if (can_load) begin
					s_next.tidx = tidx_inc;
					s_next.tx_valid = 1'b1;
					s_next.tx_last = 1'b0;
					if (s_reg.tidx < s_reg.rsp_len) begin
						s_next.tx_byte = tx_src;
						s_next.crc = tx_crc_next;
						if (s_reg.kind == mbh_pkg::MBH_RSP_READ && tidx_inc >= `MBH_LEN_READ_HDR)
							s_next.map_addr = start + {9'h000, 7'((tidx_inc - `MBH_LEN_READ_HDR) >> 1)};
					end else if (s_reg.tidx == s_reg.rsp_len) begin
						s_next.tx_byte = s_reg.crc[7:0];
					end else if (s_reg.tidx == s_reg.rsp_len + 7'h01) begin
						s_next.tx_byte = s_reg.crc[15:8];
						s_next.tx_last = 1'b1;
					end else begin
						s_next.tx_valid = 1'b0;
						s_next.tidx = s_reg.tidx;
						s_next.len = '0;
						s_next.crc = `MBH_CRC_INIT;
						s_next.st = mbh_pkg::MBH_ST_IDLE;
					end
				end
			end
		endcase
		// A restart clears the statistics and the overrun flag; the frame in hand carries on
		if (comm_restart) begin
			s_next.cnt = '0; // RL13
			// An overrun caught in this same cycle survives the restart: set wins
			s_next.diag = {15'h0000, ovr_event};
			s_next.ovr_flag = ovr_event;
		end
	end

	// ==========================================
	// State register, synchronous reset
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			s_reg <= '0; // RL13
			s_reg.st <= mbh_pkg::MBH_ST_IDLE;
			s_reg.crc <= `MBH_CRC_INIT;
		end else
			s_reg <= s_next;
	end

	assign tx_valid     = s_reg.tx_valid;
	assign tx_byte      = s_reg.tx_byte;
	assign tx_last      = s_reg.tx_last;
	assign map_addr     = s_reg.map_addr;
	assign map_wr_data  = s_reg.map_wr_data;
	assign map_wr_en    = s_reg.map_wr_en;
	assign overrun_flag = s_reg.ovr_flag;

	// ==========================================
	// Checks
	a_qty_range: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL1
		s_reg.st == mbh_pkg::MBH_ST_DECODE && fc == `MBH_FC_WRITE && (qty == 16'h0000 || qty > `MBH_MAX_QTY)
		|=> s_reg.exc_code == `MBH_EXC_VALUE && s_reg.st == mbh_pkg::MBH_ST_REPLY)
		else $error("bad quantity not refused with code 3");
	a_byte_total: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL2
		s_reg.st == mbh_pkg::MBH_ST_DECODE && fc == `MBH_FC_WRITE && qty != 16'h0000 && qty <= `MBH_MAX_QTY
		&& bc != {qty[6:0], 1'b0} |=> s_reg.exc_code == `MBH_EXC_VALUE)
		else $error("byte total mismatch not refused");
	a_start_item: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL6
		s_reg.st == mbh_pkg::MBH_ST_CHECK && fc == `MBH_FC_WRITE && s_reg.idx == 5'h00 && !map_item_first
		|=> s_reg.exc_code == `MBH_EXC_ADDR ##1 s_reg.st == mbh_pkg::MBH_ST_SEND || broadcast)
		else $error("misaligned start not refused with code 2");
	a_protect_code: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL5
		s_reg.st == mbh_pkg::MBH_ST_CHECK && fc == `MBH_FC_WRITE && map_addr_ok && map_mapped && !map_writable
		&& (s_reg.idx != 5'h00 || map_item_first) |=> s_reg.exc_code == `MBH_EXC_DEVICE)
		else $error("protected register write not refused");
	a_write_gaps: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL7
		map_wr_en |-> $past(map_mapped) && s_reg.exc_code == `MBH_EXC_NONE && $stable(map_addr))
		else $error("write strobe into gap or after fault");
	a_tail_item: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL8
		s_reg.st == mbh_pkg::MBH_ST_CHECK && fc == `MBH_FC_WRITE && map_addr_ok && last_reg && map_mapped
		&& !map_item_end && (s_reg.idx != 5'h00 || map_item_first) |=> s_reg.exc_code == `MBH_EXC_DEVICE)
		else $error("partial item write not refused");
	a_read_total: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL11
		s_reg.st == mbh_pkg::MBH_ST_SEND && s_reg.kind == mbh_pkg::MBH_RSP_READ && s_reg.tidx == 7'h03 && tx_valid
		|-> tx_byte == {qty[6:0], 1'b0})
		else $error("read byte count wrong");
	a_clear_all: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL13
		s_reg.st == mbh_pkg::MBH_ST_DECODE && fc == `MBH_FC_DIAG && start == `MBH_SUB_CLEAR
		|=> s_reg.cnt == '0 && s_reg.diag == 16'h0000 ##1 s_reg.cnt[`MBH_CNT_BUS] == 16'h0000)
		else $error("counters not cleared");
	a_crc_count: assert property (@(posedge sys_clk) disable iff (!reset_n || comm_restart) // RL15
		s_reg.st == mbh_pkg::MBH_ST_IDLE && rx_valid && rx_last && rx_crc_next != 16'h0000
		|=> s_reg.cnt[`MBH_CNT_CRC] == $past(s_reg.cnt[`MBH_CNT_CRC]) + 16'h0001)
		else $error("CRC error not counted");
	a_ovr_clear: assert property (@(posedge sys_clk) disable iff (!reset_n || comm_restart) // RL22
		s_reg.st == mbh_pkg::MBH_ST_DECODE && fc == `MBH_FC_DIAG && start == `MBH_SUB_CLR_OVR
		|=> s_reg.cnt[`MBH_CNT_OVR] == 16'h0000 && !overrun_flag
		&& s_reg.cnt[`MBH_CNT_SLAVE] == $past(s_reg.cnt[`MBH_CNT_SLAVE]))
		else $error("overrun clear touched wrong state");
	a_exc_func: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL25
		s_reg.st == mbh_pkg::MBH_ST_SEND && s_reg.kind == mbh_pkg::MBH_RSP_EXC && s_reg.tidx == 7'h02 && tx_valid
		|-> tx_byte == (fc | `MBH_EXC_FLAG))
		else $error("exception function byte wrong");
endmodule // mbh_handler

// ---- rtl/mbh_consts.svh ----
`ifndef MBH_CONSTS_SVH
`define MBH_CONSTS_SVH
// ==========================================
// Function and exception codes
`define MBH_FC_READ        8'h03
`define MBH_FC_DIAG        8'h08
`define MBH_FC_WRITE       8'h10
`define MBH_EXC_FLAG       8'h80
`define MBH_EXC_NONE       8'h00
`define MBH_EXC_FUNC       8'h01
`define MBH_EXC_ADDR       8'h02
`define MBH_EXC_VALUE      8'h03
`define MBH_EXC_DEVICE     8'h04
`define MBH_BROADCAST      8'h00
// ==========================================
// Diagnostic sub-functions
`define MBH_SUB_ECHO       16'h0000
`define MBH_SUB_CLEAR      16'h000A
`define MBH_SUB_CNT_FIRST  16'h000B
`define MBH_SUB_CNT_LAST   16'h0012
`define MBH_SUB_CLR_OVR    16'h0014
// ==========================================
// Counter slots, sub-function 11 upward
`define MBH_CNT_NUM        8
`define MBH_CNT_BUS        3'h0
`define MBH_CNT_CRC        3'h1
`define MBH_CNT_EXC        3'h2
`define MBH_CNT_SLAVE      3'h3
`define MBH_CNT_NORESP     3'h4
`define MBH_CNT_NAK        3'h5
`define MBH_CNT_BUSY       3'h6
`define MBH_CNT_OVR        3'h7
// ==========================================
// Frame layout and sizes
`define MBH_BUF_DEPTH      64
`define MBH_LEN_W          7
`define MBH_POS_ADDR       0
`define MBH_POS_FC         1
`define MBH_POS_HI         2
`define MBH_POS_LO         3
`define MBH_POS_QTY_HI     4
`define MBH_POS_QTY_LO     5
`define MBH_POS_BC         6
`define MBH_POS_DATA       7
`define MBH_MIN_FRAME      7'h08
`define MBH_WR_OVERHEAD    7'h09
`define MBH_MAX_QTY        16'h0010
`define MBH_ADDR_SPACE     17'h10000
`define MBH_LEN_EXC        7'h03
`define MBH_LEN_ECHO_HDR   7'h06
`define MBH_LEN_READ_HDR   7'h03
`define MBH_LEN_CRC        7'h02
`define MBH_CRC_INIT       16'hFFFF
`define MBH_CRC_POLY       16'hA001
`endif

// ---- rtl/mbh_pkg.sv ----
`include "mbh_consts.svh"
package mbh_pkg;
	// ==========================================
	// Controller states and reply kinds
	typedef enum logic [2:0] {MBH_ST_IDLE, MBH_ST_DECODE, MBH_ST_CHECK, MBH_ST_WRITE, MBH_ST_REPLY,
		MBH_ST_SEND} mbh_state_type;
	typedef enum logic [1:0] {MBH_RSP_EXC, MBH_RSP_ECHO, MBH_RSP_COUNTER, MBH_RSP_READ} mbh_resp_type;
	// ==========================================
	// Whole module state, registered as one word
	typedef struct packed {
		mbh_state_type                           st;
		mbh_resp_type                            kind;
		logic [`MBH_BUF_DEPTH-1:0][7:0]          rx_buf;
		logic [`MBH_LEN_W-1:0]                   len;
		logic                                    ovr_seen;
		logic [15:0]                             crc;
		logic [4:0]                              idx;
		logic                                    phase;
		logic [`MBH_LEN_W-1:0]                   tidx;
		logic [`MBH_LEN_W-1:0]                   rsp_len;
		logic [7:0]                              exc_code;
		logic [`MBH_CNT_NUM-1:0][15:0]           cnt;
		logic                                    ovr_flag;
		logic [15:0]                             diag;
		logic                                    tx_valid;
		logic [7:0]                              tx_byte;
		logic                                    tx_last;
		logic [15:0]                             map_addr;
		logic [15:0]                             map_wr_data;
		logic                                    map_wr_en;
	} mbh_state_type_reg_type;
endpackage

// ---- rtl/mbh_crc16.sv ----
`timescale 1ns/1ps
`include "mbh_consts.svh"
// ==========================================
// One byte step of the reflected serial-line CRC
module mbh_crc16 (
	input  wire logic [15:0] crc_in,
	input  wire logic [7:0]  data,
	output logic      [15:0] crc_out
);
	// Bitwise loop keeps the polynomial in one place
	always_comb begin
		logic [15:0] c;
		c = crc_in ^ {8'h00, data};
		for (int b = 0; b < 8; b++) begin
			c = c[0] ? ((c >> 1) ^ `MBH_CRC_POLY) : (c >> 1);
		end
		crc_out = c;
	end
endmodule // mbh_crc16

// ---- verification/mbh_map_model.sv ----
`timescale 1ns/1ps
// ==========================================
// Holding-register map: words 00..0F writable, two-word items 10..1F,
// gap 20..2F, read-only 30..3F, address space ends at 00FF
module mbh_map_model (
	input  wire logic        sys_clk,
	input  wire logic [15:0] map_addr,
	input  wire logic [15:0] map_wr_data,
	input  wire logic        map_wr_en,
	output logic             map_addr_ok,
	output logic             map_mapped,
	output logic             map_item_first,
	output logic             map_item_end,
	output logic             map_writable,
	output logic             map_value_ok,
	output logic      [15:0] map_rd_data
);
	logic [15:0] mem [0:63];
	logic        pair;
	// Answers are combinational, the handler samples them in the same cycle
	always_comb begin
		pair           = map_addr[15:4] == 12'h001;
		map_addr_ok    = map_addr < 16'h0100;
		map_mapped     = map_addr < 16'h0020 || (map_addr >= 16'h0030 && map_addr < 16'h0040);
		map_item_first = pair ? ~map_addr[0] : 1'b1;
		map_item_end   = pair ? map_addr[0] : 1'b1;
		map_writable   = map_addr < 16'h0030;
		map_value_ok   = map_wr_data <= 16'h1000;
		// Gaps read junk, so a handler that forwards it instead of zero is caught
		map_rd_data    = map_mapped ? mem[map_addr[5:0]] : 16'hA5A5;
	end
	// Known preload pattern
	initial begin
		for (int i = 0; i < 64; i++) begin
			mem[i] = {8'h00, i[7:0]};
		end
	end
	// Storage of written words
	always @(posedge sys_clk) begin
		if (map_wr_en) begin
			mem[map_addr[5:0]] <= map_wr_data;
		end
	end
endmodule // mbh_map_model

// ---- verification/tb.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; \
	$display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb;
	typedef logic [7:0] mbh_tb_q_type[$];
	localparam logic [7:0] ME = 8'h11;
	logic        sys_clk = 0, reset_n = 0, comm_restart = 0, rx_valid = 0, rx_last = 0, rx_overrun = 0, tx_ready = 1;
	logic        tx_valid, tx_last, map_wr_en, overrun_flag, map_addr_ok, map_mapped, map_item_first;
	logic        map_item_end, map_writable, map_value_ok, slow = 0;
	logic [7:0]  rx_byte = 8'h00, tx_byte;
	logic [15:0] map_addr, map_wr_data, map_rd_data;
	int          n_errors = 0, n_checks = 0;
	// Clock, 50 ns period
	always #25 sys_clk = ~sys_clk;
	mbh_handler i_dut (.sys_clk, .reset_n, .own_address(ME), .comm_restart, .rx_valid, .rx_byte, .rx_last,
		.rx_overrun, .tx_ready, .map_addr_ok, .map_mapped, .map_item_first, .map_item_end, .map_writable,
		.map_value_ok, .map_rd_data, .tx_valid, .tx_byte, .tx_last, .map_addr, .map_wr_data, .map_wr_en,
		.overrun_flag);
	mbh_map_model i_map (.sys_clk, .map_addr, .map_wr_data, .map_wr_en, .map_addr_ok, .map_mapped,
		.map_item_first, .map_item_end, .map_writable, .map_value_ok, .map_rd_data);
	// ==========================================
	// Helpers
	function automatic mbh_tb_q_type crc(mbh_tb_q_type q, bit bad);
		logic [15:0] c = 16'hFFFF;
		foreach (q[i]) begin
			c ^= {8'h00, q[i]};
			for (int k = 0; k < 8; k++) begin
				c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
			end
		end
		return {q, c[7:0] ^ {8{bad}}, c[15:8]};
	endfunction
	task automatic step();
		@(posedge sys_clk);
		#5;
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// Send one frame; md bit0 overrun, bit1 bad CRC, bit2 count word unknown. Empty exp: no reply allowed
	task automatic xfer(mbh_tb_q_type req, mbh_tb_q_type exp, logic [2:0] md, output mbh_tb_q_type got);
		int n = 0;
		bit done = 0;
		req = crc(req, md[1]);
		got = {};
		foreach (req[i]) begin
			rx_valid = 1;
			rx_byte = req[i];
			rx_last = i == req.size() - 1;
			rx_overrun = md[0] && i == 0;
			step();
		end
		rx_valid = 0;
		rx_last = 0;
		rx_overrun = 0;
		// Sampled mid-cycle so the accepting edge is seen without a race
		while (!done && n < (exp.size() > 0 ? 400 : 40)) begin
			@(negedge sys_clk);
			if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
				got.push_back(tx_byte);
				done = tx_last === 1'b1;
			end
			step();
			tx_ready = slow ? ~tx_ready : 1'b1;
			n++;
		end
		if (exp.size() == 0) begin
			`CHK(got.size(), 0)
		end else begin
			if (!done) begin
				n_errors++;
				wrap_up();
			end
			if (md[2]) begin
				exp[4] = got[4];
				exp[5] = got[5];
			end
			exp = crc(exp, 0);
			`CHK(got.size(), exp.size())
			foreach (exp[i]) `CHK(got[i], exp[i])
		end
	endtask
	task automatic cnt(logic [7:0] sub, output logic [15:0] v);
		mbh_tb_q_type r, g;
		r = {ME, 8'h08, 8'h00, sub, 8'h00, 8'h00};
		xfer(r, r, 3'h4, g);
		v = {g[4], g[5]};
	endtask
	task automatic wq(logic [15:0] s, logic [15:0] q, logic [7:0] bc, logic [15:0] v, logic [7:0] e);
		mbh_tb_q_type r, x, g;
		r = {ME, 8'h10, s[15:8], s[7:0], q[15:8], q[7:0], bc};
		for (int i = 0; i < bc; i += 2) r = {r, v[15:8], v[7:0]};
		x = {ME, 8'h90, e};
		if (e == 8'h00) x = r[0:5];
		xfer(r, x, 3'h0, g);
	endtask
	// ==========================================
	// Scenarios
	task automatic t_write();
		mbh_tb_q_type r, x, g;
		wq(16'h0005, 16'h0001, 8'h02, 16'h0055, 8'h00);
		slow = 1;
		wq(16'h001E, 16'h0004, 8'h08, 16'h0001, 8'h00);
		slow = 0;
		wq(16'h0000, 16'h0000, 8'h00, 16'h0000, 8'h03);
		wq(16'h0000, 16'h0011, 8'h22, 16'h0000, 8'h03);
		wq(16'h0005, 16'h0001, 8'h04, 16'h0077, 8'h03);
		wq(16'h00FF, 16'h0002, 8'h04, 16'h0000, 8'h02);
		wq(16'h0011, 16'h0001, 8'h02, 16'h0000, 8'h02);
		wq(16'h0005, 16'h0001, 8'h02, 16'h2000, 8'h04);
		wq(16'h0030, 16'h0001, 8'h02, 16'h0001, 8'h04);
		wq(16'h0010, 16'h0001, 8'h02, 16'h0001, 8'h04);
		r = {ME, 8'h03, 8'h00, 8'h05, 8'h00, 8'h01};
		x = {ME, 8'h03, 8'h02, 8'h00, 8'h55};
		xfer(r, x, 3'h0, g);
		r = {ME, 8'h03, 8'h00, 8'h1E, 8'h00, 8'h04};
		x = {ME, 8'h03, 8'h08, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
		xfer(r, x, 3'h0, g);
	endtask
	task automatic t_diag();
		mbh_tb_q_type r, x, e, g;
		logic [15:0] a, b;
		logic [7:0]  z[5] = '{8'h0C, 8'h0D, 8'h10, 8'h11, 8'h12};
		r = {ME, 8'h08, 8'h00, 8'h00, 8'h12, 8'h34, 8'hAB, 8'hCD};
		xfer(r, r, 3'h0, g);
		r = {ME, 8'h08, 8'h00, 8'h03, 8'h00, 8'h00};
		x = {ME, 8'h88, 8'h01};
		xfer(r, x, 3'h0, g);
		r = {ME, 8'h08, 8'h00, 8'h0A, 8'h00, 8'h00};
		xfer(r, r, 3'h0, g);
		foreach (z[i]) begin
			cnt(z[i], a);
			`CHK(a, 16'h0000)
		end
		// A corrupted clear frame must be counted, not obeyed
		cnt(8'h0C, a);
		xfer(r, e, 3'h2, g);
		cnt(8'h0C, b);
		`CHK(b, a + 16'h0001)
		cnt(8'h0B, a);
		r[0] = 8'h22;
		xfer(r, e, 3'h0, g);
		cnt(8'h0B, b);
		`CHK(b, a + 16'h0002)
		cnt(8'h0D, a);
		r = {ME, 8'h05, 8'h00, 8'h00, 8'h00, 8'h01};
		x = {ME, 8'h85, 8'h01};
		xfer(r, x, 3'h0, g);
		cnt(8'h0D, b);
		`CHK(b, a + 16'h0001)
		cnt(8'h0E, a);
		cnt(8'h0E, b);
		`CHK(b, a + 16'h0001)
		cnt(8'h0F, a);
		r = {8'h00, 8'h10, 8'h00, 8'h06, 8'h00, 8'h01, 8'h02, 8'h00, 8'h66};
		xfer(r, e, 3'h0, g);
		r = {ME, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00};
		xfer(r, e, 3'h1, g);
		cnt(8'h0F, b);
		`CHK(b, a + 16'h0002)
		cnt(8'h12, a);
		`CHK(a, 16'h0001)
		`CHK(overrun_flag, 1'b1)
		cnt(8'h0C, a);
		r = {ME, 8'h08, 8'h00, 8'h14, 8'h00, 8'h00};
		xfer(r, r, 3'h0, g);
		cnt(8'h12, b);
		`CHK(b, 16'h0000)
		`CHK(overrun_flag, 1'b0)
		cnt(8'h0C, b);
		`CHK(b, a)
		comm_restart = 1;
		step();
		comm_restart = 0;
		cnt(8'h0C, a);
		`CHK(a, 16'h0000)
	endtask
	// ==========================================
	// Main sequence
	initial begin
		repeat (4) step();
		reset_n = 1;
		`CHK(overrun_flag, 1'b0)
		t_write();
		t_diag();
		wrap_up();
	end
endmodule // tb
